//--- hdl/mac_pkg.sv
// package: register codes, control field layout and constants of the multiply-accumulate unit
package mac_pkg;

	// ---------------------------------------------------------------
	// register addressing
	// ---------------------------------------------------------------
	// compact code: low hex digit is the module, upper digits the index
	localparam int         MAC_MOD_W    = 4;
	localparam int         MAC_IDX_W    = 5;
	localparam int         MAC_ADDR_W   = MAC_MOD_W + MAC_IDX_W;
	localparam logic [3:0] MAC_MODULE   = 4'h2;
	localparam logic [4:0] MAC_IDX_CTRL = 5'h00;
	localparam logic [4:0] MAC_IDX_OPA  = 5'h01;
	localparam logic [4:0] MAC_IDX_OPB  = 5'h02;
	localparam logic [4:0] MAC_IDX_RLO  = 5'h04;
	localparam logic [4:0] MAC_IDX_RHI  = 5'h05;
	localparam logic [4:0] MAC_IDX_CLO  = 5'h0B;
	localparam logic [4:0] MAC_IDX_CHI  = 5'h0C;

	// ---------------------------------------------------------------
	// multiplier_control field layout
	// ---------------------------------------------------------------
	localparam int MAC_SET_W     = 5;  // settings in bits 4:0
	localparam int MAC_BIT_CLEAR = 5;  // write 1 clears the unit, reads 0
	localparam int MAC_BIT_OVF   = 6;  // overflow flag, read only

	localparam int         MAC_DATA_W   = 32;
	localparam int         MAC_ACC_W    = 64;
	localparam logic [4:0] MAC_CTRL_RST = 5'h00;
	localparam logic [31:0] MAC_WORD_RST = 32'h0000_0000;
	localparam logic [63:0] MAC_ACC_RST  = 64'h0000_0000_0000_0000;

	// settings carried as one packed group, msb first
	typedef struct packed {
		logic square;   // bit 4: written value used as both factors
		logic single;   // bit 3: any operand write starts an operation
		logic negate;   // bit 2: subtract product when accumulating
		logic acc_en;   // bit 1: accumulate instead of replace
		logic sgn;      // bit 0: two's complement operands
	} mac_ctrl_t;

endpackage : mac_pkg

//--- hdl/mac_unit.sv
// module: 32 x 32 multiply-accumulate unit on the core register port
// What this block does
// - a 32x32 product is formed and, when accumulating, added into the 64-bit accumulator in one cycle.
// - after an operation starts the unit takes the next one two cycles later.
// - two operand registers and two result pairs, each pair a 64-bit value in low and high words.
// - a control bit selects unsigned or two's complement operands.
// - a control bit selects replace-with-product or add-product-to-accumulator.
// - with negate and accumulate both set the product is subtracted from the accumulator.
// - a control bit selects start on both operands loaded or on any single operand write.
// - in square mode any operand write starts an operation squaring the written value.
// - the clear control zeroes operands, results, accumulator and all flags.
// - results read back the cycle after the last operand write and feed a new accumulate one cycle on.
// - two-operand operations can never overrun the unit.
// - each register is addressed by index in the upper digits and module in the low hex digit.
`timescale 1ns/1ps
module mac_unit (
	input  wire logic        ref_clk,    // core clock, 250 MHz
	input  wire logic        arst_n,     // async reset, active low
	input  wire logic [8:0]  reg_addr,   // compact register code
	input  wire logic        reg_wr,     // write strobe
	input  wire logic        reg_rd,     // read strobe
	input  wire logic [31:0] reg_wdata,  // write data
	output logic      [31:0] reg_rdata,  // read data, one cycle after strobe
	output logic             overflow    // overrun flag (also in control)
);

	// ---------------------------------------------------------------
	// address decode
	// ---------------------------------------------------------------
	// code = {index, module}
	wire logic sel_ctrl = reg_addr == {mac_pkg::MAC_IDX_CTRL, mac_pkg::MAC_MODULE};
	wire logic sel_opa  = reg_addr == {mac_pkg::MAC_IDX_OPA, mac_pkg::MAC_MODULE};
	wire logic sel_opb  = reg_addr == {mac_pkg::MAC_IDX_OPB, mac_pkg::MAC_MODULE};
	wire logic sel_rlo  = reg_addr == {mac_pkg::MAC_IDX_RLO, mac_pkg::MAC_MODULE};
	wire logic sel_rhi  = reg_addr == {mac_pkg::MAC_IDX_RHI, mac_pkg::MAC_MODULE};
	wire logic sel_clo  = reg_addr == {mac_pkg::MAC_IDX_CLO, mac_pkg::MAC_MODULE};
	wire logic sel_chi  = reg_addr == {mac_pkg::MAC_IDX_CHI, mac_pkg::MAC_MODULE};
	wire logic sel_any  = sel_ctrl | sel_opa | sel_opb | sel_rlo | sel_rhi | sel_clo | sel_chi;

	wire logic wr_ctrl  = reg_wr & sel_ctrl;
	wire logic wr_a     = reg_wr & sel_opa;
	wire logic wr_b     = reg_wr & sel_opb;
	wire logic clr_req  = wr_ctrl & reg_wdata[mac_pkg::MAC_BIT_CLEAR];

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	mac_pkg::mac_ctrl_t ctrl;      // settings
	logic [31:0]        opa;       // operand_one
	logic [31:0]        opb;       // operand_two
	logic [63:0]        acc;       // result pair / accumulator
	logic [63:0]        prod_cp;   // copy pair: last signed-adjusted product
	logic               busy;      // accumulator not yet reusable
	logic               loaded_a;  // operand_one written since last start
	logic               loaded_b;  // operand_two written since last start

	// ---------------------------------------------------------------
	// trigger selection
	// ---------------------------------------------------------------
	// square and single-operand modes start on any operand write
	wire logic any_wr   = wr_a | wr_b;
	wire logic trig_one = (ctrl.single | ctrl.square) & any_wr;
	wire logic trig_two = ~(ctrl.single | ctrl.square) &
	                      ((wr_a & loaded_b) | (wr_b & loaded_a));
	wire logic trig     = trig_one | trig_two;
	// a trigger while busy is dropped and flagged; the second write of a
	// two-operand pair always lands past the busy cycle
	wire logic start    = trig & ~busy;
	wire logic overrun  = trig & busy;

	// ---------------------------------------------------------------
	// datapath
	// ---------------------------------------------------------------
	// factors take the value being written so the result is ready next cycle
	wire logic [31:0] next_opa = wr_a ? reg_wdata : opa;
	wire logic [31:0] next_opb = wr_b ? reg_wdata : opb;
	wire logic [31:0] fac_a    = ctrl.square ? reg_wdata : next_opa;
	wire logic [31:0] fac_b    = ctrl.square ? reg_wdata : next_opb;

	// 33-bit extension gives one multiplier for both signednesses
	wire logic signed [32:0] ext_a  = {ctrl.sgn & fac_a[31], fac_a};
	wire logic signed [32:0] ext_b  = {ctrl.sgn & fac_b[31], fac_b};
	wire logic signed [65:0] prod66 = ext_a * ext_b;
	wire logic [63:0]        prod   = prod66[63:0];

	wire logic [63:0] addend   = ctrl.negate ? (~prod + 64'h0000_0000_0000_0001) : prod;
	wire logic [63:0] next_acc = ctrl.acc_en ? (acc + addend) : prod;

	// ---------------------------------------------------------------
	// control register
	// ---------------------------------------------------------------
	// settings written with the clear bit are kept; clear zeroes the data
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl <= mac_pkg::mac_ctrl_t'(mac_pkg::MAC_CTRL_RST);
		end else if (wr_ctrl) begin
			ctrl <= mac_pkg::mac_ctrl_t'(reg_wdata[mac_pkg::MAC_SET_W-1:0]);
		end
	end

	// ---------------------------------------------------------------
	// operands and load flags
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			opa      <= mac_pkg::MAC_WORD_RST;
			opb      <= mac_pkg::MAC_WORD_RST;
			loaded_a <= 1'b0;
			loaded_b <= 1'b0;
		end else if (clr_req) begin
			opa      <= mac_pkg::MAC_WORD_RST;
			opb      <= mac_pkg::MAC_WORD_RST;
			loaded_a <= 1'b0;
			loaded_b <= 1'b0;
		end else begin
			opa      <= next_opa;
			opb      <= next_opb;
			loaded_a <= ~start & (loaded_a | wr_a);
			loaded_b <= ~start & (loaded_b | wr_b);
		end
	end

	// ---------------------------------------------------------------
	// results, busy and overflow
	// ---------------------------------------------------------------
	// busy lasts one cycle: accumulator feeds a new op two cycles after start
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			acc      <= mac_pkg::MAC_ACC_RST;
			prod_cp  <= mac_pkg::MAC_ACC_RST;
			busy     <= 1'b0;
			overflow <= 1'b0;
		end else if (clr_req) begin
			acc      <= mac_pkg::MAC_ACC_RST;
			prod_cp  <= mac_pkg::MAC_ACC_RST;
			busy     <= 1'b0;
			overflow <= 1'b0;
		end else begin
			busy     <= start;
			overflow <= overflow | overrun;
			if (start) begin
				acc     <= next_acc;
				prod_cp <= prod;
			end
		end
	end

	// ---------------------------------------------------------------
	// read path
	// ---------------------------------------------------------------
	// unmapped codes read zero; registered so the output comes from a flop
	wire logic [31:0] ctrl_word = {25'h0000000, overflow, 1'b0, ctrl};
	wire logic [31:0] rd_mux    = sel_ctrl ? ctrl_word    :
	                              sel_opa  ? opa          :
	                              sel_opb  ? opb          :
	                              sel_rlo  ? acc[31:0]    :
	                              sel_rhi  ? acc[63:32]   :
	                              sel_clo  ? prod_cp[31:0]:
	                              sel_chi  ? prod_cp[63:32] : mac_pkg::MAC_WORD_RST;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= mac_pkg::MAC_WORD_RST;
		end else if (reg_rd) begin
			reg_rdata <= rd_mux;
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	property p_mul_only;
		@(posedge ref_clk) disable iff (!arst_n)
		(start && !ctrl.acc_en && !ctrl.sgn && !ctrl.square && !clr_req) |=>
			acc == ({32'h0, $past(next_opa)} * {32'h0, $past(next_opb)});
	endproperty
	a_mul_only: assert property (p_mul_only) else $error("product wrong");

	property p_ready;
		@(posedge ref_clk) disable iff (!arst_n)
		start |=> busy ##1 !busy;
	endproperty
	a_ready: assert property (p_ready) else $error("ready spacing wrong");

	property p_square;
		@(posedge ref_clk) disable iff (!arst_n)
		(start && ctrl.square && !ctrl.sgn) |=>
			prod_cp == ({32'h0, $past(reg_wdata)} * {32'h0, $past(reg_wdata)});
	endproperty
	a_square: assert property (p_square) else $error("square wrong");

	property p_clear;
		@(posedge ref_clk) disable iff (!arst_n)
		clr_req |=> (acc == 64'h0 && opa == 32'h0 && opb == 32'h0 && !overflow && !busy);
	endproperty
	a_clear: assert property (p_clear) else $error("clear incomplete");

	property p_overrun;
		@(posedge ref_clk) disable iff (!arst_n)
		(start ##1 trig) |=> overflow && $stable(acc);
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not flagged");

	property p_sticky;
		@(posedge ref_clk) disable iff (!arst_n)
		(overflow && !clr_req) |=> overflow;
	endproperty
	a_sticky: assert property (p_sticky) else $error("overflow dropped");

	property p_two_op;
		@(posedge ref_clk) disable iff (!arst_n)
		(!ctrl.single && !ctrl.square && reg_wr && !clr_req) |=> overflow == $past(overflow);
	endproperty
	a_two_op: assert property (p_two_op) else $error("two-operand overrun");

	property p_readback;
		@(posedge ref_clk) disable iff (!arst_n)
		(start ##1 (reg_rd && sel_rlo)) |=> reg_rdata == $past(next_acc[31:0], 2);
	endproperty
	a_readback: assert property (p_readback) else $error("result not readable");

	property p_negate;
		@(posedge ref_clk) disable iff (!arst_n)
		(start && ctrl.acc_en && ctrl.negate && !clr_req) |=> acc + prod_cp == $past(acc);
	endproperty
	a_negate: assert property (p_negate) else $error("negate wrong");

	// ---------------------------------------------------------------
	// assertions on results, starts, the overflow flag and the read port
	// ---------------------------------------------------------------
	// accumulate without negate adds the raw product onto the old sum
	property p_acc_sum;
		@(posedge ref_clk) disable iff (!arst_n)
		(start && ctrl.acc_en && !ctrl.negate) |=> acc == $past(acc) + prod_cp;
	endproperty
	a_acc_sum: assert property (p_acc_sum) else $error("accumulate wrong");

	// multiply-only leaves the product itself in the result pair
	property p_replace;
		@(posedge ref_clk) disable iff (!arst_n)
		(start && !ctrl.acc_en) |=> acc == prod_cp;
	endproperty
	a_replace: assert property (p_replace) else $error("replace wrong");

	// signed mode: full 64-bit two's complement product
	property p_signed;
		@(posedge ref_clk) disable iff (!arst_n)
		(start && ctrl.sgn && !ctrl.square) |=>
			$signed(prod_cp) == ($signed($past(next_opa)) * $signed($past(next_opb)));
	endproperty
	a_signed: assert property (p_signed) else $error("signed product wrong");

	// results only move on a start or a clear, so a dropped op leaves them
	property p_hold;
		@(posedge ref_clk) disable iff (!arst_n)
		(!start && !clr_req) |=> $stable(acc) && $stable(prod_cp);
	endproperty
	a_hold: assert property (p_hold) else $error("result moved");

	// two-operand mode: a lone operand_one write never starts
	property p_two_wait;
		@(posedge ref_clk) disable iff (!arst_n)
		(!ctrl.single && !ctrl.square && wr_a && !loaded_b) |-> !start;
	endproperty
	a_two_wait: assert property (p_two_wait) else $error("early start");

	// single-operand mode: any operand write while idle starts at once
	property p_single;
		@(posedge ref_clk) disable iff (!arst_n)
		(ctrl.single && any_wr && !busy) |-> start;
	endproperty
	a_single: assert property (p_single) else $error("single start missed");

	// read data holds between reads; software may poll it late
	property p_rd_hold;
		@(posedge ref_clk) disable iff (!arst_n)
		!reg_rd |=> $stable(reg_rdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");

	// control reads show the flag and never the clear bit
	property p_ctrl_read;
		@(posedge ref_clk) disable iff (!arst_n)
		(reg_rd && sel_ctrl) |=> !reg_rdata[mac_pkg::MAC_BIT_CLEAR] &&
			reg_rdata[mac_pkg::MAC_BIT_OVF] == $past(overflow);
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

	// codes outside this module read zero
	property p_unmapped;
		@(posedge ref_clk) disable iff (!arst_n)
		(reg_rd && !sel_any) |=> reg_rdata == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");

	// the flag only rises on a trigger
	property p_ovf_rise;
		@(posedge ref_clk) disable iff (!arst_n)
		(!overflow && !trig) |=> !overflow;
	endproperty
	a_ovf_rise: assert property (p_ovf_rise) else $error("spurious overflow");

endmodule : mac_unit

//--- tb/mac_host.sv
// host core model: issues register writes and reads to the unit
`timescale 1ns/1ps
module mac_host (
	input  wire logic        ref_clk,    // core clock
	output logic      [8:0]  reg_addr,   // compact register code
	output logic             reg_wr,     // write strobe
	output logic             reg_rd,     // read strobe
	output logic      [31:0] reg_wdata,  // write data
	input  wire logic [31:0] reg_rdata   // read data
);
	// ---------------------------------------------------------------
	// idle bus at time zero
	// ---------------------------------------------------------------
	initial begin
		reg_addr = 9'h000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 32'h0000_0000;
	end

	// every task starts just after an edge and returns just after the edge that took it
	task automatic wr(input logic [4:0] idx, input logic [31:0] d);
		reg_addr = {idx, mac_pkg::MAC_MODULE};
		reg_wdata = d;
		reg_wr = 1'b1;
		reg_rd = 1'b0;
		@(posedge ref_clk);
		#1;
	endtask : wr

	task automatic rd(input logic [4:0] idx, output logic [31:0] d);
		reg_addr = {idx, mac_pkg::MAC_MODULE};
		reg_wr = 1'b0;
		reg_rd = 1'b1;
		@(posedge ref_clk);
		#1;
		d = reg_rdata;
	endtask : rd

	// spacing cycles; stale data inverted so nothing leans on it
	task automatic idle(input int n);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = ~reg_wdata;
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : idle
endmodule : mac_host

//--- tb/tb_mac_unit.sv
// self-checking bench for the multiply-accumulate unit
`timescale 1ns/1ps
module tb_mac_unit;
	logic        ref_clk;      // core clock
	logic        arst_n;       // async reset, active low
	logic [8:0]  reg_addr;     // register code from host
	logic        reg_wr;       // write strobe
	logic        reg_rd;       // read strobe
	logic [31:0] reg_wdata;    // write data
	logic [31:0] reg_rdata;    // read data from unit
	logic        overflow;     // overrun flag
	int          n_fail;       // mismatches
	int          checks_done;  // comparisons

	mac_host host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	mac_unit dut (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .overflow(overflow));

	// 250 MHz core clock
	initial ref_clk = 1'b0;
	always #2 ref_clk = ~ref_clk;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic rc(input logic [4:0] idx, input logic [31:0] exp);
		logic [31:0] v;
		host.rd(idx, v);
		chk(v, exp);
	endtask : rc

	task automatic wc(input logic [31:0] d); host.wr(mac_pkg::MAC_IDX_CTRL, d); endtask : wc
	task automatic wa(input logic [31:0] d); host.wr(mac_pkg::MAC_IDX_OPA, d); endtask : wa
	task automatic wb(input logic [31:0] d); host.wr(mac_pkg::MAC_IDX_OPB, d); endtask : wb

	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up

	// watchdog: the sequence needs well under a microsecond
	initial begin
		#20000;
		n_fail++;
		wrap_up();
	end

	// ---------------------------------------------------------------
	// test sequence
	// ---------------------------------------------------------------
	initial begin
		n_fail = 0;
		checks_done = 0;
		arst_n = 1'b0;
		repeat (10) @(posedge ref_clk);
		#1 arst_n = 1'b1;
		rc(mac_pkg::MAC_IDX_CTRL, 32'h0000_0000);
		rc(5'h03, 32'h0000_0000);
		// full-scale unsigned product, both result pairs
		wa(32'hFFFF_FFFF);
		wb(32'hFFFF_FFFF);
		rc(mac_pkg::MAC_IDX_RLO, 32'h0000_0001);
		rc(mac_pkg::MAC_IDX_RHI, 32'hFFFF_FFFE);
		rc(mac_pkg::MAC_IDX_CHI, 32'hFFFF_FFFE);
		rc(mac_pkg::MAC_IDX_OPA, 32'hFFFF_FFFF);
		// signed: -1 times 3
		wc(32'h0000_0001);
		wa(32'hFFFF_FFFF);
		wb(32'h0000_0003);
		rc(mac_pkg::MAC_IDX_RHI, 32'hFFFF_FFFF);
		// one operand alone must not start in two-operand mode
		wa(32'h0000_0007);
		rc(mac_pkg::MAC_IDX_RLO, 32'hFFFF_FFFD);
		// clear plus accumulate, back-to-back pairs: 10 + 12
		wc(32'h0000_0023);
		rc(mac_pkg::MAC_IDX_CTRL, 32'h0000_0003);
		wa(32'h0000_0002);
		wb(32'h0000_0005);
		wa(32'h0000_0003);
		wb(32'h0000_0004);
		rc(mac_pkg::MAC_IDX_RLO, 32'h0000_0016);
		chk({31'h0, overflow}, 32'h0000_0000);
		// negate: accumulator -10, copy keeps raw product
		wc(32'h0000_0027);
		wa(32'h0000_0002);
		wb(32'h0000_0005);
		rc(mac_pkg::MAC_IDX_RLO, 32'hFFFF_FFF6);
		rc(mac_pkg::MAC_IDX_RHI, 32'hFFFF_FFFF);
		rc(mac_pkg::MAC_IDX_CLO, 32'h0000_000A);
		// single operand: 0*4 then 5*4
		wc(32'h0000_002A);
		wb(32'h0000_0004);
		host.idle(1);
		wa(32'h0000_0005);
		rc(mac_pkg::MAC_IDX_RLO, 32'h0000_0014);
		// square at minimum spacing: 9 + 16
		wc(32'h0000_0032);
		wa(32'h0000_0003);
		host.idle(1);
		wb(32'h0000_0004);
		rc(mac_pkg::MAC_IDX_RLO, 32'h0000_0019);
		chk({31'h0, overflow}, 32'h0000_0000);
		// overrun: second square dropped, operand still stored
		wa(32'h0000_0005);
		wb(32'h0000_0006);
		rc(mac_pkg::MAC_IDX_RLO, 32'h0000_0032);
		rc(mac_pkg::MAC_IDX_OPB, 32'h0000_0006);
		chk({31'h0, overflow}, 32'h0000_0001);
		host.idle(5);
		rc(mac_pkg::MAC_IDX_CTRL, 32'h0000_0052);
		// clear wipes everything
		wc(32'h0000_0020);
		rc(mac_pkg::MAC_IDX_CTRL, 32'h0000_0000);
		rc(mac_pkg::MAC_IDX_OPA, 32'h0000_0000);
		rc(mac_pkg::MAC_IDX_CLO, 32'h0000_0000);
		chk({31'h0, overflow}, 32'h0000_0000);
		// overrun again, then a mid-run reset drops the sticky flag
		wc(32'h0000_0010);
		wa(32'h0000_0002);
		wb(32'h0000_0003);
		chk({31'h0, overflow}, 32'h0000_0001);
		arst_n = 1'b0;
		@(posedge ref_clk);
		#1 arst_n = 1'b1;
		chk({31'h0, overflow}, 32'h0000_0000);
		rc(mac_pkg::MAC_IDX_CTRL, 32'h0000_0000);
		wrap_up();
	end
endmodule : tb_mac_unit
